// file: common/cpu_timing_pkg.sv
package cpu_timing_pkg;

   // register map, byte offsets on the plain register port
   localparam logic [7:0] ADDR_DP0_LOW = 8'h82;
   localparam logic [7:0] ADDR_DP0_HIGH = 8'h83;
   localparam logic [7:0] ADDR_DP1_LOW = 8'h84;
   localparam logic [7:0] ADDR_DP1_HIGH = 8'h85;
   localparam logic [7:0] ADDR_POINTER_SELECT = 8'h86;
   localparam logic [7:0] ADDR_STRETCH = 8'h8E;
   localparam logic [7:0] ADDR_PORT2_LATCH = 8'hA0;
   localparam logic [7:0] ADDR_STATUS = 8'hD0;
   localparam logic [7:0] ADDR_BANK_LIMIT = 8'h1F;

   // status word bit positions
   localparam int STATUS_CY = 7;
   localparam int STATUS_AC = 6;
   localparam int STATUS_RS1 = 4;
   localparam int STATUS_RS0 = 3;
   localparam int STATUS_OV = 2;

   // reset values
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [15:0] RESET_POINTER = 16'h0000;
   localparam logic [2:0] RESET_STRETCH = 3'h0;

   // cycle figures
   localparam logic [3:0] ONE_CYCLE = 4'h1;
   localparam logic [3:0] FIRST_DATA_CYCLE = 4'h2;
   localparam logic [3:0] MOVE_MIN_CYCLES = 4'h2;
   localparam logic [3:0] MOVE_MAX_CYCLES = 4'h9;
   localparam logic [3:0] MAX_PLAIN_CYCLES = 4'h5;

   // decimal adjust figures
   localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
   localparam logic [8:0] BCD_LOW_FIX = 9'h006;
   localparam logic [8:0] BCD_HIGH_FIX = 9'h060;

   typedef enum logic [1:0] {
      FIRST_STATE,
      SECOND_STATE,
      THIRD_STATE,
      FOURTH_STATE
   } state_t;

   typedef enum logic [4:0] {
      OP_NONE,
      OP_ADD,
      ADD_WITH_CARRY_OP,
      SUBTRACT_BORROW_OP,
      MULTIPLY_OP,
      OP_DIVIDE,
      DECIMAL_ADJUST_OP,
      ROTATE_RIGHT_THROUGH_CARRY_OP,
      ROTATE_LEFT_THROUGH_CARRY_OP,
      CLEAR_CARRY_OP,
      SET_CARRY_OP,
      COMPLEMENT_CARRY_OP,
      AND_BIT_INTO_CARRY_OP,
      OR_BIT_INTO_CARRY_OP,
      MOVE_BIT_INTO_CARRY_OP,
      COMPARE_JUMP_NOT_EQUAL_OP,
      OP_INC_POINTER_SELECT
   } op_t;

   // one decoded instruction as handed over at its first state
   typedef struct packed {
      logic [2:0] bytes;      // instruction length in bytes
      logic branch;           // jump or call: one address cycle more
      logic [1:0] extra;      // further cycles beyond length
      logic ext_move;         // external data move
      logic move_by_pointer;  // 1: selected pointer, 0: index register
      logic move_write;       // 1: write strobe, 0: read strobe
      logic index_sel;        // which index register of the bank
      op_t op;
      logic [7:0] operand_a;
      logic [7:0] operand_b;
      logic bit_in;           // bit operand, already inverted if needed
   } instr_t;

   typedef struct packed {
      logic cy;
      logic ac;
      logic ov;
      logic wr_cy;
      logic wr_ac;
      logic wr_ov;
   } flags_t;

endpackage

// file: src/cpu_cycle_timing_and_pointer_select.sv
`timescale 1ns/100ps
`default_nettype none

// Functional notes
// RULE1 - every machine cycle is four states, stepped first to fourth in order
// RULE2 - at most one fetch per machine cycle, so one fetch spans four clocks
// RULE3 - most instructions take as many machine cycles as they have bytes
// RULE4 - jumps and calls take one machine cycle more than their byte count
// RULE5 - half the opcodes finish in a single four-clock machine cycle
// RULE6 - durations range one to five cycles; some single-byte opcodes take two
// RULE7 - both clock edges are used; clock duty cycle should be near half
// RULE8 - external data move lasts two to nine machine cycles, user selectable
// RULE9 - read or write strobe stretches in proportion to added cycles
// RULE10 - external move reaches off-chip memory and mapped peripherals, classic results
// RULE11 - index form: low address from bank index register, high from port 2 latch
// RULE12 - pointer form: full 16-bit address from the selected data pointer
// RULE13 - two data pointers; select bit zero picks first, one picks second
// RULE14 - upper seven select register bits do nothing and read zero
// RULE15 - increment of select register toggles the active data pointer
// RULE16 - results and flag effects match the classic instruction set
// RULE17 - add, add with carry, subtract set carry, overflow, aux; mul/div clear carry
// RULE18 - adjust, rotates, carry bit ops, compare set carry; clear 0, set 1
// RULE19 - two bank bits choose one of four 8-byte banks at 00h-1Fh
// RULE20 - reset restarts at first state, select bit zero, minimum move length
module cpu_cycle_timing_and_pointer_select (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   // register port
   input wire logic [7:0] i_reg_addr,
   input wire logic [7:0] i_reg_wdata,
   input wire logic i_reg_wr,
   input wire logic i_reg_rd,
   output logic [7:0] o_reg_rdata,
   // instruction hand-over from the decoder
   output logic o_instr_begin,
   input wire logic i_instr_valid,
   input wire cpu_timing_pkg::instr_t i_instr,
   output logic o_fetch,
   output logic o_instr_done,
   output cpu_timing_pkg::state_t o_state,
   // external data space
   output logic [15:0] o_ext_addr,
   output logic [7:0] o_ext_wdata,
   input wire logic [7:0] i_ext_rdata,
   output logic [7:0] o_ext_rdata,
   output logic o_ext_rd_n,
   output logic o_ext_wr_n
);
   import cpu_timing_pkg::*;

   state_t state;
   logic busy;
   instr_t cur;
   logic [3:0] cycle_idx;
   logic [3:0] cycle_total;
   logic pointer_select_bit;
   logic [15:0] data_pointer_zero;
   logic [15:0] data_pointer_one;
   logic [2:0] stretch;
   logic [7:0] port2_latch;
   logic [7:0] status;
   logic [7:0] index_regs [0:7];
   logic last_state;
   logic take;
   logic strobe_window;
   flags_t next_flags;
   logic [7:0] next_rdata;

   // cycle count of one instruction
   function automatic logic [3:0] cycles_for(instr_t ins, logic [2:0] str);
      logic [3:0] n;
      n = 4'h0;
      if (ins.ext_move) begin
         n = MOVE_MIN_CYCLES + {1'b0, str}; // RULE8
      end else begin
         n = {1'b0, ins.bytes} + {3'h0, ins.branch} + {2'h0, ins.extra}; // RULE3 RULE4 RULE6
         if (n < ONE_CYCLE) begin
            n = ONE_CYCLE; // RULE5
         end
         if (n > MAX_PLAIN_CYCLES) begin
            n = MAX_PLAIN_CYCLES;
         end
      end
      return n;
   endfunction

   // whether an address falls inside the bank area
   function automatic logic in_banks(logic [7:0] addr);
      return addr <= ADDR_BANK_LIMIT;
   endfunction

   // flag effects of one operation
   function automatic flags_t alu_flags(op_t op, logic [7:0] a, logic [7:0] b,
                                        logic cy_in, logic ac_in, logic bit_in);
      flags_t f;
      logic [8:0] sum;
      logic [4:0] low;
      logic [8:0] cin;
      logic [4:0] lcin;
      logic [15:0] prod;
      logic [8:0] adj;
      f = '0;
      cin = (op == OP_ADD) ? 9'h000 : {8'h00, cy_in};
      lcin = (op == OP_ADD) ? 5'h00 : {4'h0, cy_in};
      sum = 9'h000;
      low = 5'h00;
      prod = 16'h0000;
      adj = {1'b0, a};
      case (op)
         OP_ADD, ADD_WITH_CARRY_OP: begin
            sum = {1'b0, a} + {1'b0, b} + cin;
            low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + lcin;
            f = '{cy: sum[8], ac: low[4], ov: (a[7] == b[7]) && (sum[7] != a[7]),
                  wr_cy: 1'b1, wr_ac: 1'b1, wr_ov: 1'b1}; // RULE17
         end
         SUBTRACT_BORROW_OP: begin
            sum = {1'b0, a} - {1'b0, b} - cin;
            low = {1'b0, a[3:0]} - {1'b0, b[3:0]} - lcin;
            f = '{cy: sum[8], ac: low[4], ov: (a[7] != b[7]) && (sum[7] != a[7]),
                  wr_cy: 1'b1, wr_ac: 1'b1, wr_ov: 1'b1}; // RULE17
         end
         MULTIPLY_OP: begin
            prod = {8'h00, a} * {8'h00, b};
            f = '{cy: 1'b0, ac: 1'b0, ov: prod[15:8] != 8'h00,
                  wr_cy: 1'b1, wr_ac: 1'b0, wr_ov: 1'b1}; // RULE17
         end
         OP_DIVIDE: begin
            // overflow only when the divisor is zero
            f = '{cy: 1'b0, ac: 1'b0, ov: b == 8'h00,
                  wr_cy: 1'b1, wr_ac: 1'b0, wr_ov: 1'b1}; // RULE17
         end
         DECIMAL_ADJUST_OP: begin
            if (ac_in || (adj[3:0] > BCD_DIGIT_MAX)) begin
               adj = adj + BCD_LOW_FIX;
            end
            // carry is only ever set here, never cleared
            if (cy_in || adj[8] || (adj[7:4] > BCD_DIGIT_MAX)) begin
               adj = adj + BCD_HIGH_FIX;
            end
            f = '{cy: cy_in || adj[8], ac: 1'b0, ov: 1'b0,
                  wr_cy: 1'b1, wr_ac: 1'b0, wr_ov: 1'b0}; // RULE18
         end
         ROTATE_RIGHT_THROUGH_CARRY_OP: f = '{a[0], 1'b0, 1'b0, 1'b1, 1'b0, 1'b0}; // RULE18
         ROTATE_LEFT_THROUGH_CARRY_OP: f = '{a[7], 1'b0, 1'b0, 1'b1, 1'b0, 1'b0}; // RULE18
         CLEAR_CARRY_OP: f = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0}; // RULE18
         SET_CARRY_OP: f = '{1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0}; // RULE18
         COMPLEMENT_CARRY_OP: f = '{!cy_in, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0}; // RULE18
         AND_BIT_INTO_CARRY_OP: f = '{cy_in && bit_in, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0}; // RULE18
         OR_BIT_INTO_CARRY_OP: f = '{cy_in || bit_in, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0}; // RULE18
         MOVE_BIT_INTO_CARRY_OP: f = '{bit_in, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0}; // RULE18
         COMPARE_JUMP_NOT_EQUAL_OP: f = '{a < b, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0}; // RULE18
         default: f = '0;
      endcase
      return f;
   endfunction

   // sequencing terms
   assign last_state = (state == FOURTH_STATE);
   assign o_instr_begin = (state == FIRST_STATE) && !busy;
   assign take = o_instr_begin && i_instr_valid;
   assign o_state = state;

   // one fetch per cycle, only in the byte-carrying cycles; address cycles stay quiet
   assign o_fetch = (state == FIRST_STATE) &&
                    (!busy || (cycle_idx <= {1'b0, cur.bytes})); // RULE2

   // four states in fixed order, restart at first state on reset
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         state <= FIRST_STATE; // RULE20
      end else begin
         case (state)
            FIRST_STATE: state <= SECOND_STATE; // RULE1
            SECOND_STATE: state <= THIRD_STATE; // RULE1
            THIRD_STATE: state <= FOURTH_STATE; // RULE1
            FOURTH_STATE: state <= FIRST_STATE; // RULE1
            default: state <= FIRST_STATE;
         endcase
      end
   end

   // instruction cycle counter
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         busy <= 1'b0;
         cur <= '0;
         cycle_idx <= ONE_CYCLE;
         cycle_total <= ONE_CYCLE;
      end else if (take) begin
         busy <= 1'b1;
         cur <= i_instr;
         cycle_idx <= ONE_CYCLE;
         cycle_total <= cycles_for(i_instr, stretch); // RULE3 RULE4 RULE8
      end else if (busy && last_state) begin
         if (cycle_idx == cycle_total) begin
            busy <= 1'b0;
         end else begin
            cycle_idx <= cycle_idx + ONE_CYCLE;
         end
      end
   end

   // completion pulse in the cycle after the last fourth state
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_instr_done <= 1'b0;
      end else begin
         o_instr_done <= busy && last_state && (cycle_idx == cycle_total);
      end
   end

   // external address and write data, latched as the move starts
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_ext_addr <= RESET_POINTER;
         o_ext_wdata <= RESET_BYTE;
      end else if (take && i_instr.ext_move) begin // RULE10
         o_ext_wdata <= i_instr.operand_a;
         if (i_instr.move_by_pointer) begin
            o_ext_addr <= pointer_select_bit ? data_pointer_one : data_pointer_zero; // RULE12 RULE13
         end else begin
            o_ext_addr <= {port2_latch,
                           index_regs[{status[STATUS_RS1], status[STATUS_RS0],
                                       i_instr.index_sel}]}; // RULE11 RULE19
         end
      end
   end

   // read data taken at the close of the move
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_ext_rdata <= RESET_BYTE;
      end else if (busy && last_state && (cycle_idx == cycle_total) &&
                   cur.ext_move && !cur.move_write) begin
         o_ext_rdata <= i_ext_rdata;
      end
   end

   // strobe window covers every cycle after the address cycle except the final fourth state, so it grows with stretch
   assign strobe_window = busy && cur.ext_move && (cycle_idx >= FIRST_DATA_CYCLE) &&
                          !(last_state && (cycle_idx == cycle_total)); // RULE9

   // strobes move on the falling edge; they fall three and a half states after the address change
   always_ff @(negedge i_clk) begin
      if (i_sys_rst) begin
         o_ext_rd_n <= 1'b1;
         o_ext_wr_n <= 1'b1;
      end else begin
         o_ext_rd_n <= !(strobe_window && !cur.move_write); // RULE7 RULE9
         o_ext_wr_n <= !(strobe_window && cur.move_write); // RULE7 RULE9
      end
   end

   // flag effect of the running instruction
   always_comb begin
      next_flags = alu_flags(cur.op, cur.operand_a, cur.operand_b,
                             status[STATUS_CY], status[STATUS_AC], cur.bit_in); // RULE16
   end

   // status word; the completing instruction wins over a same-cycle software write
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         status <= RESET_BYTE;
      end else begin
         if (i_reg_wr && (i_reg_addr == ADDR_STATUS)) begin
            status <= i_reg_wdata;
         end
         if (busy && last_state && (cycle_idx == cycle_total)) begin
            if (next_flags.wr_cy) begin
               status[STATUS_CY] <= next_flags.cy; // RULE17 RULE18
            end
            if (next_flags.wr_ac) begin
               status[STATUS_AC] <= next_flags.ac; // RULE17
            end
            if (next_flags.wr_ov) begin
               status[STATUS_OV] <= next_flags.ov; // RULE17
            end
         end
      end
   end

   // pointer select bit; an increment toggles and wins over a same-cycle software write
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         pointer_select_bit <= 1'b0; // RULE20
      end else if (busy && last_state && (cycle_idx == cycle_total) &&
                   (cur.op == OP_INC_POINTER_SELECT)) begin
         pointer_select_bit <= !pointer_select_bit; // RULE15
      end else if (i_reg_wr && (i_reg_addr == ADDR_POINTER_SELECT)) begin
         pointer_select_bit <= i_reg_wdata[0]; // RULE13 RULE14
      end
   end

   // both data pointers, byte-wide software access
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         data_pointer_zero <= RESET_POINTER;
         data_pointer_one <= RESET_POINTER;
      end else if (i_reg_wr) begin
         case (i_reg_addr)
            ADDR_DP0_LOW: data_pointer_zero[7:0] <= i_reg_wdata;
            ADDR_DP0_HIGH: data_pointer_zero[15:8] <= i_reg_wdata;
            ADDR_DP1_LOW: data_pointer_one[7:0] <= i_reg_wdata;
            ADDR_DP1_HIGH: data_pointer_one[15:8] <= i_reg_wdata;
            default: ;
         endcase
      end
   end

   // move length and port 2 latch
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         stretch <= RESET_STRETCH; // RULE20
         port2_latch <= RESET_BYTE;
      end else if (i_reg_wr) begin
         if (i_reg_addr == ADDR_STRETCH) begin
            stretch <= i_reg_wdata[2:0]; // RULE8
         end
         if (i_reg_addr == ADDR_PORT2_LATCH) begin
            port2_latch <= i_reg_wdata;
         end
      end
   end

   // only the two index registers of each bank are held; the rest of a bank reads zero
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         for (int i = 0; i < 8; i++) begin
            index_regs[i] <= RESET_BYTE;
         end
      end else if (i_reg_wr && in_banks(i_reg_addr) && (i_reg_addr[2:1] == 2'h0)) begin
         index_regs[{i_reg_addr[4:3], i_reg_addr[0]}] <= i_reg_wdata; // RULE19
      end
   end

   // read mux
   always_comb begin
      next_rdata = RESET_BYTE;
      if (in_banks(i_reg_addr)) begin
         if (i_reg_addr[2:1] == 2'h0) begin
            next_rdata = index_regs[{i_reg_addr[4:3], i_reg_addr[0]}];
         end
      end else begin
         case (i_reg_addr)
            ADDR_DP0_LOW: next_rdata = data_pointer_zero[7:0];
            ADDR_DP0_HIGH: next_rdata = data_pointer_zero[15:8];
            ADDR_DP1_LOW: next_rdata = data_pointer_one[7:0];
            ADDR_DP1_HIGH: next_rdata = data_pointer_one[15:8];
            ADDR_POINTER_SELECT: next_rdata = {7'h00, pointer_select_bit}; // RULE14
            ADDR_STRETCH: next_rdata = {5'h00, stretch};
            ADDR_PORT2_LATCH: next_rdata = port2_latch;
            ADDR_STATUS: next_rdata = status;
            default: next_rdata = RESET_BYTE;
         endcase
      end
   end

   // read data one cycle after the strobe, zero otherwise
   always_ff @(posedge i_clk) begin
      if (i_sys_rst) begin
         o_reg_rdata <= RESET_BYTE;
      end else if (i_reg_rd) begin
         o_reg_rdata <= next_rdata;
      end else begin
         o_reg_rdata <= RESET_BYTE;
      end
   end

endmodule

`default_nettype wire

// file: verification/cpu_timing_props.sv
`timescale 1ns/100ps
`default_nettype none
// watches sequencing and strobe shape from the top-level pins only
module cpu_timing_props (
   input wire logic i_clk,
   input wire logic i_sys_rst,
   input wire logic [7:0] i_reg_addr,
   input wire logic i_reg_rd,
   input wire logic [7:0] o_reg_rdata,
   input wire cpu_timing_pkg::state_t o_state,
   input wire logic o_instr_begin,
   input wire logic o_instr_done,
   input wire logic o_fetch,
   input wire logic o_ext_rd_n,
   input wire logic o_ext_wr_n
);
   import cpu_timing_pkg::*;
   default clocking @(posedge i_clk);
   endclocking
   default disable iff (i_sys_rst);
   // state order, instruction boundaries on the first state
   state_step_a: assert property (1'b1 |=> o_state == state_t'($past(o_state) + 2'd1))
      else $error("state out of order");
   begin_first_a: assert property (o_instr_begin |-> o_state == FIRST_STATE)
      else $error("begin outside first state");
   fetch_first_a: assert property (o_fetch |-> o_state == FIRST_STATE)
      else $error("fetch off first state");
   done_first_a: assert property (o_instr_done |-> o_state == FIRST_STATE && o_instr_begin)
      else $error("done off boundary");
   done_gap_a: assert property (o_instr_done |=> (!o_instr_done)[*3])
      else $error("done pulses too close");
   select_upper_a: assert property (i_reg_rd && i_reg_addr == ADDR_POINTER_SELECT
      |=> o_reg_rdata[7:1] == 7'h00) else $error("select upper bits set");
   // strobes open in the first state of cycle two and never shorter than the minimum move
   read_fall_a: assert property ($fell(o_ext_rd_n) |-> o_state == FIRST_STATE ##1 (!o_ext_rd_n)[*2])
      else $error("read strobe shape");
   write_fall_a: assert property ($fell(o_ext_wr_n) |-> o_state == FIRST_STATE ##1 (!o_ext_wr_n)[*2])
      else $error("write strobe shape");
   strobe_end_a: assert property ($rose(o_ext_rd_n) || $rose(o_ext_wr_n)
      |-> o_state == FOURTH_STATE ##1 o_instr_done) else $error("strobe end not before done");
   strobe_excl_a: assert property (o_ext_rd_n || o_ext_wr_n)
      else $error("both strobes low");
   strobe_busy_a: assert property (!o_ext_rd_n || !o_ext_wr_n |-> !o_instr_begin)
      else $error("strobe while idle");
endmodule
bind cpu_cycle_timing_and_pointer_select cpu_timing_props i_cpu_timing_props (
   .i_clk(i_clk),
   .i_sys_rst(i_sys_rst),
   .i_reg_addr(i_reg_addr),
   .i_reg_rd(i_reg_rd),
   .o_reg_rdata(o_reg_rdata),
   .o_state(o_state),
   .o_instr_begin(o_instr_begin),
   .o_instr_done(o_instr_done),
   .o_fetch(o_fetch),
   .o_ext_rd_n(o_ext_rd_n),
   .o_ext_wr_n(o_ext_wr_n)
);
`default_nettype wire

// file: verification/ext_data_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
// only the low address byte decodes; the bench checks the full address
module ext_data_mem_model #(
   parameter int ACCESS_NS = 8,
   parameter int HOLD_NS = 3
) (
   input wire logic [15:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_rd_n,
   input wire logic i_wr_n,
   output logic [7:0] o_rdata
);
   logic [7:0] mem [0:255];
   initial o_rdata = 8'hA5;
   // data after the access time; a short strobe catches noise
   always @(negedge i_rd_n) begin
      #ACCESS_NS;
      if (!i_rd_n) o_rdata = mem[i_addr[7:0]];
   end
   // released bus flips after the hold time
   always @(posedge i_rd_n) begin
      #HOLD_NS;
      if (i_rd_n) o_rdata = ~o_rdata;
   end
   // write lands on strobe release
   always @(posedge i_wr_n) mem[i_addr[7:0]] = i_wdata;
endmodule
`default_nettype wire

// file: verification/cpu_cycle_timing_and_pointer_select_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module cpu_cycle_timing_and_pointer_select_tb_top;
   import cpu_timing_pkg::*;
   typedef struct packed {op_t op; logic [7:0] a; logic [7:0] b; logic bi; logic [2:0] f;} fcase_t;
   typedef struct packed {logic [2:0] by; logic br; logic [1:0] ex; logic [3:0] n;} ccase_t;
   // carry, aux, overflow after each step; carry chains into the next step
   localparam fcase_t FC [15] = '{
      '{OP_ADD, 8'h80, 8'h80, 1'b0, 3'h5}, '{ADD_WITH_CARRY_OP, 8'h0F, 8'h01, 1'b0, 3'h2},
      '{SUBTRACT_BORROW_OP, 8'h00, 8'h01, 1'b0, 3'h6}, '{MULTIPLY_OP, 8'h10, 8'h10, 1'b0, 3'h3},
      '{OP_DIVIDE, 8'h05, 8'h01, 1'b0, 3'h2}, '{SET_CARRY_OP, 8'h00, 8'h00, 1'b0, 3'h6},
      '{COMPLEMENT_CARRY_OP, 8'h00, 8'h00, 1'b0, 3'h2},
      '{ROTATE_RIGHT_THROUGH_CARRY_OP, 8'h01, 8'h00, 1'b0, 3'h6},
      '{AND_BIT_INTO_CARRY_OP, 8'h00, 8'h00, 1'b0, 3'h2},
      '{OR_BIT_INTO_CARRY_OP, 8'h00, 8'h00, 1'b1, 3'h6},
      '{CLEAR_CARRY_OP, 8'h00, 8'h00, 1'b0, 3'h2},
      '{ROTATE_LEFT_THROUGH_CARRY_OP, 8'h80, 8'h00, 1'b0, 3'h6},
      '{MOVE_BIT_INTO_CARRY_OP, 8'h00, 8'h00, 1'b0, 3'h2},
      '{DECIMAL_ADJUST_OP, 8'h9A, 8'h00, 1'b0, 3'h6},
      '{COMPARE_JUMP_NOT_EQUAL_OP, 8'h02, 8'h01, 1'b0, 3'h2}};
   localparam ccase_t CC [5] = '{'{3'h1, 1'b0, 2'h0, 4'h1}, '{3'h2, 1'b0, 2'h0, 4'h2},
      '{3'h3, 1'b1, 2'h0, 4'h4}, '{3'h1, 1'b0, 2'h1, 4'h2}, '{3'h3, 1'b1, 2'h1, 4'h5}};
   localparam int LIMIT = 5000;
   logic i_clk = 1'b0;
   logic i_sys_rst = 1'b1;
   logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
   logic reg_wstb = 1'b0, reg_rd = 1'b0;
   logic instr_valid = 1'b0;
   instr_t instr = '0;
   logic [7:0] reg_rdata, ext_wdata, ext_rdata_in, ext_rdata;
   logic [15:0] ext_addr;
   logic instr_begin, instr_done, ext_rd_n, ext_wr_n;
   int err_count = 0, checks = 0, cyc = 0;

   always #2.5 i_clk = ~i_clk;

   cpu_cycle_timing_and_pointer_select i_cpu_cycle_timing_and_pointer_select (
      .i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata),
      .i_reg_wr(reg_wstb), .i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata),
      .o_instr_begin(instr_begin), .i_instr_valid(instr_valid), .i_instr(instr), .o_fetch(),
      .o_instr_done(instr_done), .o_state(), .o_ext_addr(ext_addr), .o_ext_wdata(ext_wdata),
      .i_ext_rdata(ext_rdata_in), .o_ext_rdata(ext_rdata), .o_ext_rd_n(ext_rd_n),
      .o_ext_wr_n(ext_wr_n));
   ext_data_mem_model i_ext_data_mem_model (.i_addr(ext_addr), .i_wdata(ext_wdata),
      .i_rd_n(ext_rd_n), .i_wr_n(ext_wr_n), .o_rdata(ext_rdata_in));

   task automatic final_report();
      if (err_count == 0 && checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   // register port: one-cycle strobes, read data only in the following cycle
   task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wstb <= 1'b1;
      @(posedge i_clk);
      reg_wstb <= 1'b0;
   endtask

   task automatic reg_rd_val(input logic [7:0] a, output logic [7:0] d);
      @(posedge i_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge i_clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask

   function automatic instr_t mk(logic [2:0] by, logic br, logic [1:0] ex, op_t op,
      logic [7:0] a, logic [7:0] b, logic bi);
      instr_t t;
      t = '0;
      t.bytes = by;
      t.branch = br;
      t.extra = ex;
      t.op = op;
      t.operand_a = a;
      t.operand_b = b;
      t.bit_in = bi;
      return t;
   endfunction

   function automatic instr_t mv(logic ptr, logic wr, logic sel, logic [7:0] d);
      instr_t t;
      t = mk(3'h1, 1'b0, 2'h0, OP_NONE, d, d, 1'b0);
      t.ext_move = 1'b1;
      t.move_by_pointer = ptr;
      t.move_write = wr;
      t.index_sel = sel;
      return t;
   endfunction

   // offer until taken; count clocks to done, take cycle included, and strobe lows
   task automatic run(input instr_t t, output int n, output int rl, output int wl);
      n = 1;
      rl = 0;
      wl = 0;
      @(posedge i_clk);
      instr_valid <= 1'b1;
      instr <= t;
      @(negedge i_clk);
      while (instr_begin !== 1'b1) @(negedge i_clk);
      @(posedge i_clk);
      instr_valid <= 1'b0;
      #1;
      while (instr_done !== 1'b1 && n < 60) begin
         @(posedge i_clk);
         #1;
         n++;
         if (ext_rd_n === 1'b0) rl++;
         if (ext_wr_n === 1'b0) wl++;
      end
   endtask

   task automatic t_regs();
      logic [7:0] d;
      reg_rd_val(ADDR_POINTER_SELECT, d);
      cmp({8'h00, d}, 16'h0000, "select after reset");
      reg_wr(ADDR_POINTER_SELECT, 8'hFF);
      reg_rd_val(ADDR_POINTER_SELECT, d);
      cmp({8'h00, d}, 16'h0001, "select upper bits");
      reg_rd_val(8'h90, d);
      cmp({8'h00, d}, 16'h0000, "unmapped read");
      reg_wr(ADDR_DP0_LOW, 8'h34);
      reg_wr(ADDR_DP0_HIGH, 8'h12);
      reg_wr(ADDR_DP1_LOW, 8'hCD);
      reg_wr(ADDR_DP1_HIGH, 8'hAB);
      reg_rd_val(ADDR_DP1_HIGH, d);
      cmp({8'h00, d}, 16'h00AB, "second pointer");
   endtask

   task automatic t_cycles();
      int n, rl, wl;
      foreach (CC[k]) begin
         run(mk(CC[k].by, CC[k].br, CC[k].ex, OP_NONE, 8'h00, 8'h00, 1'b0), n, rl, wl);
         cmp(16'(n), {10'h000, CC[k].n, 2'b00}, "cycle count");
      end
   endtask

   task automatic t_flags();
      int n, rl, wl;
      logic [7:0] d;
      reg_wr(ADDR_STATUS, 8'h00);
      foreach (FC[k]) begin
         run(mk(3'h1, 1'b0, 2'h0, FC[k].op, FC[k].a, FC[k].b, FC[k].bi), n, rl, wl);
         reg_rd_val(ADDR_STATUS, d);
         cmp({13'h0000, d[STATUS_CY], d[STATUS_AC], d[STATUS_OV]}, {13'h0000, FC[k].f},
            "flags");
      end
   endtask

   task automatic t_moves();
      int n, rl, wl;
      logic [7:0] d;
      i_ext_data_mem_model.mem[8'h34] = 8'hC3;
      i_ext_data_mem_model.mem[8'h77] = 8'hE1;
      reg_wr(ADDR_POINTER_SELECT, 8'h00);
      run(mv(1'b1, 1'b0, 1'b0, 8'h00), n, rl, wl);
      cmp(16'(n), 16'd8, "short move");
      cmp(ext_addr, 16'h1234, "first pointer addr");
      cmp({8'h00, ext_rdata}, 16'h00C3, "read data");
      cmp(16'(rl * 16 + wl), 16'h0030, "read strobe");
      run(mk(3'h1, 1'b0, 2'h0, OP_INC_POINTER_SELECT, 8'h00, 8'h00, 1'b0), n, rl, wl);
      reg_rd_val(ADDR_POINTER_SELECT, d);
      cmp({8'h00, d}, 16'h0001, "toggle");
      run(mv(1'b1, 1'b1, 1'b0, 8'h5A), n, rl, wl);
      cmp(ext_addr, 16'hABCD, "second pointer addr");
      cmp(16'(rl * 16 + wl), 16'h0003, "write strobe");
      cmp({8'h00, i_ext_data_mem_model.mem[8'hCD]}, 16'h005A, "write data");
      // bank two, second index register, longest stretch
      reg_wr(ADDR_STATUS, 8'h10);
      reg_wr(8'h11, 8'h77);
      reg_wr(ADDR_PORT2_LATCH, 8'h3C);
      reg_wr(ADDR_STRETCH, 8'h07);
      run(mv(1'b0, 1'b0, 1'b1, 8'h00), n, rl, wl);
      cmp(ext_addr, 16'h3C77, "index addr");
      cmp(16'(n), 16'd36, "long move");
      cmp(16'(rl), 16'd31, "long strobe");
      cmp({8'h00, ext_rdata}, 16'h00E1, "index data");
      // second reset between moves, while idle, must drop the stretch back to minimum
      @(posedge i_clk);
      i_sys_rst <= 1'b1;
      repeat (2) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      reg_rd_val(ADDR_STRETCH, d);
      cmp({8'h00, d}, 16'h0000, "stretch after reset");
      run(mv(1'b1, 1'b0, 1'b0, 8'h00), n, rl, wl);
      cmp(16'(n), 16'd8, "move after reset");
   endtask

   // hang guard, well above the few hundred cycles the run needs
   always @(posedge i_clk) begin
      cyc++;
      if (cyc == LIMIT) begin
         err_count++;
         final_report();
      end
   end

   initial begin
      repeat (20) @(posedge i_clk);
      i_sys_rst <= 1'b0;
      t_regs();
      t_cycles();
      t_flags();
      t_moves();
      final_report();
   end
endmodule
`default_nettype wire
